// >>> scrl_ctrl.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scrl_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hw_standby,
	input  wire logic        sync_mode,
	input  wire logic        addr_frame_mode,
	input  wire logic        tx_load,
	input  wire logic        tx_last_bit,
	input  wire logic        rx_done,
	input  wire logic        rx_frame_err,
	input  wire logic        rx_parity_err,
	input  wire logic        rx_addr_bit,
	input  wire logic        sck_in,
	input  wire logic        bit_clk,
	output logic             tx_start,
	output logic             rx_active,
	output logic             rx_store,
	output logic             sck_out,
	output logic             sck_oe_n,
	output logic             ext_clk_sel,
	output logic             tx_empty_irq,
	output logic             rx_full_irq,
	output logic             rx_error_irq,
	output logic             tx_end_irq
);
	// ****************
	// register access
	// ****************
	logic [7:0] serial_ctrl_reg_q;
	logic       tx_holding_empty_q, rx_holding_full_q, overrun_flag_q;
	logic       framing_err_flag_q, parity_err_flag_q, tx_finished_flag_q, addr_flag_rx_q;
	logic [7:0] seen_q;
	logic       wr, rd, map_ok;
	logic [7:0] stat;
	assign pready  = 1'b1;
	assign map_ok  = (paddr == scrl_pkg::SCRL_CTRL_OFS) || (paddr == scrl_pkg::SCRL_STAT_OFS)
		|| (paddr == scrl_pkg::SCRL_CLR_OFS);
	assign pslverr = psel && penable && !map_ok;
	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign stat    = {tx_holding_empty_q, rx_holding_full_q, overrun_flag_q, framing_err_flag_q,
		parity_err_flag_q, tx_finished_flag_q, addr_flag_rx_q, 1'b0};
	wire tx_enable       = serial_ctrl_reg_q[scrl_pkg::SCRL_B_TE];
	wire rx_enable       = serial_ctrl_reg_q[scrl_pkg::SCRL_B_RE];
	wire addr_wait_on    = serial_ctrl_reg_q[scrl_pkg::SCRL_B_AWE] && !sync_mode && addr_frame_mode;
	wire ctrl_wr         = wr && paddr == scrl_pkg::SCRL_CTRL_OFS;
	// write-0 clear to status word, only for bits read as 1 before
	wire [7:0] clr_req   = (wr && paddr == scrl_pkg::SCRL_STAT_OFS) ? (~pwdata[7:0] & seen_q) : 8'h00;
	wire rx_good         = rx_done && rx_active && !(addr_wait_on && !rx_addr_bit);
	wire addr_hit        = rx_done && rx_active && addr_wait_on && rx_addr_bit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				scrl_pkg::SCRL_CTRL_OFS: prdata <= {24'h00_0000, serial_ctrl_reg_q};
				scrl_pkg::SCRL_STAT_OFS: prdata <= {24'h00_0000, stat};
				default:                 prdata <= 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 8'h00;
		end else if (rd && paddr == scrl_pkg::SCRL_STAT_OFS) begin
			seen_q <= stat;
		end else begin
			seen_q <= seen_q & ~clr_req;
		end
	end
	// ****************
	// control register
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_ctrl_reg_q <= scrl_pkg::SCRL_CTRL_RST;
		end else if (hw_standby) begin
			serial_ctrl_reg_q <= scrl_pkg::SCRL_CTRL_RST;
		end else if (ctrl_wr) begin
			serial_ctrl_reg_q <= pwdata[7:0];
		end else if (addr_hit) begin
			serial_ctrl_reg_q[scrl_pkg::SCRL_B_AWE] <= 1'b0;
		end
		// other low-power states leave the register alone
	end
	// ****************
	// status flags
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_holding_empty_q <= 1'b1;
			tx_finished_flag_q <= 1'b1;
		end else if (!tx_enable) begin
			tx_holding_empty_q <= 1'b1;
			tx_finished_flag_q <= 1'b1;
		end else begin
			if (tx_load)
				tx_holding_empty_q <= 1'b1;
			else if (clr_req[scrl_pkg::SCRL_S_THE])
				tx_holding_empty_q <= 1'b0;
			if (tx_last_bit && tx_holding_empty_q)
				tx_finished_flag_q <= 1'b1;
			else if (clr_req[scrl_pkg::SCRL_S_THE] || tx_start)
				tx_finished_flag_q <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_holding_full_q  <= 1'b0;
			overrun_flag_q     <= 1'b0;
			framing_err_flag_q <= 1'b0;
			parity_err_flag_q  <= 1'b0;
			addr_flag_rx_q     <= 1'b0;
		end else begin
			// rx_enable clear has no effect here
			if (rx_good && !rx_holding_full_q && !rx_frame_err && !rx_parity_err)
				rx_holding_full_q <= 1'b1;
			else if (clr_req[scrl_pkg::SCRL_S_RHF])
				rx_holding_full_q <= 1'b0;
			if (rx_good && rx_holding_full_q)
				overrun_flag_q <= 1'b1;
			else if (clr_req[scrl_pkg::SCRL_S_OVR])
				overrun_flag_q <= 1'b0;
			if (rx_good && rx_frame_err)
				framing_err_flag_q <= 1'b1;
			else if (clr_req[scrl_pkg::SCRL_S_FER])
				framing_err_flag_q <= 1'b0;
			if (rx_good && rx_parity_err)
				parity_err_flag_q <= 1'b1;
			else if (clr_req[scrl_pkg::SCRL_S_PER])
				parity_err_flag_q <= 1'b0;
			if (addr_hit)
				addr_flag_rx_q <= 1'b1;
			else if (rx_good)
				addr_flag_rx_q <= rx_addr_bit;
		end
	end
	assign rx_store = rx_good && !rx_holding_full_q && !rx_frame_err && !rx_parity_err;
	// ****************
	// transfer gating
	// ****************
	logic [2:0] sck_sync_q;
	logic       sck_seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_sync_q <= 3'b111;
			sck_seen_q <= 1'b0;
		end else begin
			sck_sync_q <= {sck_sync_q[1:0], sck_in};
			if (!rx_enable)
				sck_seen_q <= 1'b0;
			else if (sync_mode && sck_sync_q[2] != sck_sync_q[1] && !sck_sync_q[1])
				sck_seen_q <= 1'b1;
		end
	end
	// async: receiver shifter hunts for start bit itself while enabled
	assign rx_active = rx_enable && (!sync_mode || sck_seen_q || !ext_clk_sel);
	assign tx_start  = tx_enable && !tx_holding_empty_q && !overrun_flag_q;
	// ****************
	// clock pin role
	// ****************
	scrl_pkg::scrl_pin_e pin_role;
	always_comb begin
		if (serial_ctrl_reg_q[scrl_pkg::SCRL_B_CKX])
			pin_role = scrl_pkg::SCRL_PIN_CLK_IN;
		else if (sync_mode || serial_ctrl_reg_q[scrl_pkg::SCRL_B_CKO])
			pin_role = scrl_pkg::SCRL_PIN_CLK_OUT;
		else
			pin_role = scrl_pkg::SCRL_PIN_GPIO;
	end
	logic sck_out_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_out_q <= 1'b1;
		end else begin
			sck_out_q <= bit_clk;
		end
	end
	assign ext_clk_sel = serial_ctrl_reg_q[scrl_pkg::SCRL_B_CKX];
	assign sck_out     = sck_out_q;
	assign sck_oe_n    = (pin_role != scrl_pkg::SCRL_PIN_CLK_OUT);
	// ****************
	// requests
	// ****************
	wire rx_req_ok = !addr_wait_on;
	assign tx_empty_irq = serial_ctrl_reg_q[scrl_pkg::SCRL_B_TIE] && tx_holding_empty_q;
	assign rx_full_irq  = serial_ctrl_reg_q[scrl_pkg::SCRL_B_RIE] && rx_holding_full_q && rx_req_ok;
	assign rx_error_irq = serial_ctrl_reg_q[scrl_pkg::SCRL_B_RIE] && rx_req_ok
		&& (overrun_flag_q || framing_err_flag_q || parity_err_flag_q);
	assign tx_end_irq   = serial_ctrl_reg_q[scrl_pkg::SCRL_B_TX_END_IRQ_ENABLE] && tx_finished_flag_q;
	// ****************
	// checks
	// ****************
	property p_reset_clear;
		@(posedge pclk) disable iff (!presetn) hw_standby |=> serial_ctrl_reg_q == 8'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("ctrl not cleared");
	property p_write;
		@(posedge pclk) disable iff (!presetn) ctrl_wr && !hw_standby |=> serial_ctrl_reg_q == $past(pwdata[7:0]);
	endproperty
	a_write: assert property (p_write) else $error("ctrl write lost");
	property p_txe;
		@(posedge pclk) disable iff (!presetn) tx_empty_irq == (serial_ctrl_reg_q[7] && tx_holding_empty_q);
	endproperty
	a_txe: assert property (p_txe) else $error("tx empty req wrong");
	property p_te_off;
		@(posedge pclk) disable iff (!presetn) !tx_enable |=> tx_holding_empty_q;
	endproperty
	a_te_off: assert property (p_te_off) else $error("empty flag not forced");
	property p_rie;
		@(posedge pclk) disable iff (!presetn) !serial_ctrl_reg_q[6] |-> !rx_full_irq && !rx_error_irq;
	endproperty
	a_rie: assert property (p_rie) else $error("rx req without enable");
	property p_re_keep;
		@(posedge pclk) disable iff (!presetn) $fell(rx_enable) && !rx_done && clr_req == 8'h00
			|=> $stable(rx_holding_full_q);
	endproperty
	a_re_keep: assert property (p_re_keep) else $error("rx flag changed");
	property p_drop;
		@(posedge pclk) disable iff (!presetn) rx_done && rx_active && addr_wait_on && !rx_addr_bit |-> !rx_store;
	endproperty
	a_drop: assert property (p_drop) else $error("address wait stored");
	sequence s_hit;
		addr_hit && !ctrl_wr && !hw_standby;
	endsequence
	property p_hit;
		@(posedge pclk) disable iff (!presetn) s_hit |=> !serial_ctrl_reg_q[3] && addr_flag_rx_q;
	endproperty
	a_hit: assert property (p_hit) else $error("address hit not handled");
	property p_cko;
		@(posedge pclk) disable iff (!presetn) sync_mode && !ext_clk_sel |-> !sck_oe_n;
	endproperty
	a_cko: assert property (p_cko) else $error("sync clock not driven");
	// ****************
	// behaviour checks
	// ****************
	property p_ctrl_keep;
		@(posedge pclk) disable iff (!presetn) !ctrl_wr && !hw_standby && !addr_hit |=> $stable(serial_ctrl_reg_q);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("ctrl changed on its own");
	property p_read_ctrl;
		@(posedge pclk) disable iff (!presetn) psel && !penable && !pwrite && paddr == scrl_pkg::SCRL_CTRL_OFS
			|=> prdata == {24'h00_0000, $past(serial_ctrl_reg_q)};
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("ctrl read wrong");
	property p_txe_load;
		@(posedge pclk) disable iff (!presetn) tx_enable && tx_load |=> tx_holding_empty_q;
	endproperty
	a_txe_load: assert property (p_txe_load) else $error("empty flag not set on load");
	property p_txe_clr;
		@(posedge pclk) disable iff (!presetn) tx_enable && !tx_load && clr_req[scrl_pkg::SCRL_S_THE]
			|=> !tx_holding_empty_q;
	endproperty
	a_txe_clr: assert property (p_txe_clr) else $error("empty flag not cleared");
	property p_txe_off;
		@(posedge pclk) disable iff (!presetn) !serial_ctrl_reg_q[scrl_pkg::SCRL_B_TIE] |-> !tx_empty_irq;
	endproperty
	a_txe_off: assert property (p_txe_off) else $error("tx empty req without enable");
	property p_start;
		@(posedge pclk) disable iff (!presetn) tx_enable && !tx_holding_empty_q && !overrun_flag_q |-> tx_start;
	endproperty
	a_start: assert property (p_start) else $error("transmit not started");
	property p_rxf_level;
		@(posedge pclk) disable iff (!presetn) rx_full_irq
			== (serial_ctrl_reg_q[scrl_pkg::SCRL_B_RIE] && rx_holding_full_q && !addr_wait_on);
	endproperty
	a_rxf_level: assert property (p_rxf_level) else $error("rx full req wrong");
	property p_rxe_level;
		@(posedge pclk) disable iff (!presetn) rx_error_irq == (serial_ctrl_reg_q[scrl_pkg::SCRL_B_RIE]
			&& !addr_wait_on && (overrun_flag_q || framing_err_flag_q || parity_err_flag_q));
	endproperty
	a_rxe_level: assert property (p_rxe_level) else $error("rx error req wrong");
	property p_tei_level;
		@(posedge pclk) disable iff (!presetn) tx_end_irq
			== (serial_ctrl_reg_q[scrl_pkg::SCRL_B_TX_END_IRQ_ENABLE] && tx_finished_flag_q);
	endproperty
	a_tei_level: assert property (p_tei_level) else $error("tx end req wrong");
	property p_rx_clr;
		@(posedge pclk) disable iff (!presetn) clr_req[scrl_pkg::SCRL_S_RHF] && !rx_store |=> !rx_holding_full_q;
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("rx full not cleared");
	property p_ovr_clr;
		@(posedge pclk) disable iff (!presetn) clr_req[scrl_pkg::SCRL_S_OVR] && !(rx_good && rx_holding_full_q)
			|=> !overrun_flag_q;
	endproperty
	a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");
	property p_re_keep_err;
		@(posedge pclk) disable iff (!presetn) $fell(rx_enable) && clr_req == 8'h00
			|=> $stable({overrun_flag_q, framing_err_flag_q, parity_err_flag_q});
	endproperty
	a_re_keep_err: assert property (p_re_keep_err) else $error("rx error flag changed");
	property p_rx_off;
		@(posedge pclk) disable iff (!presetn) !rx_enable |-> !rx_active;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver active while off");
	property p_rx_async;
		@(posedge pclk) disable iff (!presetn) rx_enable && !sync_mode |-> rx_active;
	endproperty
	a_rx_async: assert property (p_rx_async) else $error("async receiver idle");
	property p_aw_ignored;
		@(posedge pclk) disable iff (!presetn) serial_ctrl_reg_q[scrl_pkg::SCRL_B_AWE] && (sync_mode || !addr_frame_mode)
			&& rx_done && rx_active && !rx_frame_err && !rx_parity_err && !rx_holding_full_q |-> rx_store;
	endproperty
	a_aw_ignored: assert property (p_aw_ignored) else $error("address wait acted outside its mode");
	sequence s_drop_frame;
		rx_done && rx_active && addr_wait_on && !rx_addr_bit && clr_req == 8'h00;
	endsequence
	property p_drop_flags;
		@(posedge pclk) disable iff (!presetn) s_drop_frame
			|=> $stable({rx_holding_full_q, framing_err_flag_q, overrun_flag_q});
	endproperty
	a_drop_flags: assert property (p_drop_flags) else $error("dropped frame set a flag");
	property p_aw_mask;
		@(posedge pclk) disable iff (!presetn) addr_wait_on |-> !rx_full_irq && !rx_error_irq;
	endproperty
	a_aw_mask: assert property (p_aw_mask) else $error("rx req during address wait");
	sequence s_last_empty;
		tx_enable && tx_last_bit && tx_holding_empty_q;
	endsequence
	property p_tx_finished_flag_set;
		@(posedge pclk) disable iff (!presetn) s_last_empty |=> tx_finished_flag_q;
	endproperty
	a_tx_finished_flag_set: assert property (p_tx_finished_flag_set) else $error("finished flag not set");
	property p_tx_finished_flag_clr;
		@(posedge pclk) disable iff (!presetn) tx_enable && clr_req[scrl_pkg::SCRL_S_THE] && !tx_last_bit
			|=> !tx_finished_flag_q;
	endproperty
	a_tx_finished_flag_clr: assert property (p_tx_finished_flag_clr) else $error("finished flag not cleared");
	property p_tei_off;
		@(posedge pclk) disable iff (!presetn) !serial_ctrl_reg_q[scrl_pkg::SCRL_B_TX_END_IRQ_ENABLE] |-> !tx_end_irq;
	endproperty
	a_tei_off: assert property (p_tei_off) else $error("tx end req without enable");
	property p_ckin;
		@(posedge pclk) disable iff (!presetn) ext_clk_sel |-> sck_oe_n;
	endproperty
	a_ckin: assert property (p_ckin) else $error("clock pin driven while input");
	property p_gpio;
		@(posedge pclk) disable iff (!presetn) !sync_mode && !serial_ctrl_reg_q[scrl_pkg::SCRL_B_CKX]
			&& !serial_ctrl_reg_q[scrl_pkg::SCRL_B_CKO] |-> sck_oe_n;
	endproperty
	a_gpio: assert property (p_gpio) else $error("clock pin driven as port");
	property p_ckout;
		@(posedge pclk) disable iff (!presetn) !sync_mode && !serial_ctrl_reg_q[scrl_pkg::SCRL_B_CKX]
			&& serial_ctrl_reg_q[scrl_pkg::SCRL_B_CKO] |-> !sck_oe_n;
	endproperty
	a_ckout: assert property (p_ckout) else $error("async clock output not driven");
	property p_sck_follow;
		@(posedge pclk) disable iff (!presetn) $past(presetn) |-> sck_out == $past(bit_clk);
	endproperty
	a_sck_follow: assert property (p_sck_follow) else $error("clock output lost bit clock");
endmodule : scrl_ctrl
`default_nettype wire

// >>> scrl_pkg.sv
// Operation
// - control register clears to zero on reset and hardware standby
// - control register holds its value through low-power states and module stop
// - all eight control bits readable and writable at any time
// - bit 7 gates transmit-empty request when holding-empty flag is set
// - transmit-empty request drops on flag clear or enable clear
// - bit 6 gates receive-full and receive-error requests
// - receive requests drop on flag clear or enable clear
// - transmit enable low disables transmit and forces holding-empty to 1
// - transmit starts when enabled and holding-empty cleared after data write; the code also holds tx_start off while the overrun flag is set
// - clearing receive enable leaves receive flags untouched
// - reception starts on start bit or on incoming serial clock
// - address-wait enable only acts in asynchronous multiprocessor format
// - address-wait drops frames with address bit 0 without flags
// - frame with address bit 1 sets status bit and clears address-wait
// - bit 2 gates transmit-end request when no data left at last bit
// - transmit-end request drops on flag clear or enable clear
// - clock select bits set clock pin role per mode
// - clock output select matters only async with internal clock
// - async internal clock output runs at bit rate
package scrl_pkg;
	localparam logic [11:0] SCRL_CTRL_OFS    = 12'h000;
	localparam logic [11:0] SCRL_STAT_OFS    = 12'h004;
	localparam logic [11:0] SCRL_CLR_OFS     = 12'h008;
	localparam logic [7:0]  SCRL_CTRL_RST    = 8'h00;
	localparam int          SCRL_B_TIE       = 7;
	localparam int          SCRL_B_RIE       = 6;
	localparam int          SCRL_B_TE        = 5;
	localparam int          SCRL_B_RE        = 4;
	localparam int          SCRL_B_AWE       = 3;
	localparam int          SCRL_B_TX_END_IRQ_ENABLE      = 2;
	localparam int          SCRL_B_CKX       = 1;
	localparam int          SCRL_B_CKO       = 0;
	// status / clear word layout
	localparam int          SCRL_S_THE       = 7;
	localparam int          SCRL_S_RHF       = 6;
	localparam int          SCRL_S_OVR       = 5;
	localparam int          SCRL_S_FER       = 4;
	localparam int          SCRL_S_PER       = 3;
	localparam int          SCRL_S_TFN       = 2;
	localparam int          SCRL_S_ADR       = 1;
	typedef enum logic [1:0] {
		SCRL_PIN_GPIO,
		SCRL_PIN_CLK_OUT,
		SCRL_PIN_CLK_IN
	} scrl_pin_e;
endpackage : scrl_pkg

// >>> scrl_remote.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-end serial device, one frame per go
// ****************************************
module scrl_remote (
	input  wire logic pclk,
	input  wire logic go,
	input  wire logic fe,
	input  wire logic pe,
	input  wire logic ab,
	output logic      busy,
	output logic      rx_done,
	output logic      rx_frame_err,
	output logic      rx_parity_err,
	output logic      rx_addr_bit,
	output logic      sck_in
);
	logic [2:0] q;
	initial begin
		busy = 1'b0;
		rx_done = 1'b0;
		sck_in = 1'b1;
		{rx_frame_err, rx_parity_err, rx_addr_bit} = 3'b000;
	end
	always begin
		@(posedge pclk iff go);
		busy <= 1'b1;
		q = {fe, pe, ab};
		#137;
		// link clock only inside the frame, 800 ns period
		repeat (8) begin
			sck_in = 1'b0;
			#400;
			sck_in = 1'b1;
			#400;
		end
		@(posedge pclk);
		rx_done <= 1'b1;
		{rx_frame_err, rx_parity_err, rx_addr_bit} <= q;
		@(posedge pclk);
		rx_done <= 1'b0;
		// released qualifiers show the inverse
		{rx_frame_err, rx_parity_err, rx_addr_bit} <= ~q;
		busy <= 1'b0;
	end
endmodule : scrl_remote
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// control register bench
// ****************************************
module tb;
	localparam logic [11:0] C = scrl_pkg::SCRL_CTRL_OFS;
	localparam logic [11:0] S = scrl_pkg::SCRL_STAT_OFS;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        hw_standby = 1'b0;
	logic        sync_mode = 1'b0;
	logic        addr_frame_mode = 1'b0;
	logic        tx_load = 1'b0;
	logic        tx_last_bit = 1'b0;
	logic        bit_clk = 1'b0;
	logic        go = 1'b0;
	logic        fe = 1'b0;
	logic        pe = 1'b0;
	logic        ab = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, busy, b, rx_done, rx_frame_err, rx_parity_err, rx_addr_bit, sck_in;
	logic        tx_start, rx_active, rx_store, sck_out, sck_oe_n, ext_clk_sel;
	logic        tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq;
	integer      mismatches = 0;
	integer      checks = 0;
	integer      stores = 0;
	integer      cm, sm, sn, i, j;
	scrl_ctrl scrl_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .hw_standby, .sync_mode, .addr_frame_mode, .tx_load, .tx_last_bit, .rx_done, .rx_frame_err,
		.rx_parity_err, .rx_addr_bit, .sck_in, .bit_clk, .tx_start, .rx_active, .rx_store, .sck_out, .sck_oe_n,
		.ext_clk_sel, .tx_empty_irq, .rx_full_irq, .rx_error_irq, .tx_end_irq);
	scrl_remote scrl_remote_inst (.pclk, .go, .fe, .pe, .ab, .busy, .rx_done, .rx_frame_err, .rx_parity_err,
		.rx_addr_bit, .sck_in);
	always #50 pclk = ~pclk;
	always begin
		repeat (4) @(posedge pclk);
		bit_clk <= ~bit_clk;
	end
	always @(posedge pclk) if (rx_store === 1'b1) stores <= stores + 1;
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic hang();
		mismatches++;
		$display("ERROR %0t: wait ran out", $time);
		final_report();
	endtask : hang
	task automatic apb(input logic w, input logic [11:0] a, input integer d);
		integer n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) hang();
	endtask : apb
	task automatic check_all();
		apb(1'b0, C, 0);
		chk(rd, cm);
		apb(1'b0, S, 0);
		chk(rd, sm);
		chk(32'({tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq}),
			32'({cm[7] & sm[7], cm[6] & sm[6], cm[6] & |sm[5:3], cm[2] & sm[2]}));
		chk(32'(stores), 32'(sn));
		chk(32'(rx_active), 32'(cm[4]));
		chk(32'(pready), 1);
	endtask : check_all
	task automatic setc(input integer v);
		cm = v;
		if (!cm[5]) sm = sm | 'h84;
		apb(1'b1, C, v);
	endtask : setc
	// read as one first, then write zero at bit b only
	task automatic clr(input integer b);
		apb(1'b0, S, 0);
		apb(1'b1, S, 'hFF & ~(1 << b));
		if (b != 7 || cm[5]) sm = sm & ~(1 << b) & ~(b == 7 ? 4 : 0);
	endtask : clr
	task automatic pulse(input logic [1:0] v);
		{tx_load, tx_last_bit} <= v;
		@(posedge pclk);
		{tx_load, tx_last_bit} <= 2'b00;
		repeat (2) @(posedge pclk);
		if (v[1]) sm = sm | 'h80;
		if (v[0] && sm[7]) sm = sm | 4;
	endtask : pulse
	task automatic frame(input logic f, input logic p, input logic a);
		integer n;
		logic aw;
		aw = cm[3] & addr_frame_mode & ~sync_mode;
		fe <= f;
		pe <= p;
		ab <= a;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (busy !== 1'b0 && n < 100);
		repeat (2) @(posedge pclk);
		if (cm[4] && !(aw && !a)) begin
			if (aw) sm = sm | 2;
			if (aw) cm = cm & ~8;
			if (sm[6]) sm = sm | 'h20;
			else if (f) sm = sm | 'h10;
			else if (p) sm = sm | 8;
			else sm = sm | 'h40;
			if (!sm[5] && !f && !p) sn++;
		end
		if (n >= 100) hang();
	endtask : frame
	initial begin
		void'($urandom(32'h9c55_c59e));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		cm = 0;
		sm = 'h84;
		sn = 0;
		check_all();
		apb(1'b0, 12'h00C, 0);
		chk(32'(err), 1);
		chk(rd, 0);
		for (i = 0; i < 8; i++) begin
			setc($urandom % 256);
			check_all();
		end
		setc('hA5);
		repeat (20) @(posedge pclk);
		check_all();
		hw_standby <= 1'b1;
		@(posedge pclk);
		hw_standby <= 1'b0;
		cm = 0;
		check_all();
		$display("test access and reset done");
		setc('h20);
		clr(7);
		chk(32'(tx_start), 1);
		setc('hA4);
		check_all();
		pulse(2'b10);
		chk(32'(tx_start), 0);
		pulse(2'b01);
		check_all();
		setc('h24);
		check_all();
		clr(7);
		check_all();
		setc('h00);
		clr(7);
		check_all();
		$display("test transmit done");
		setc('h50);
		frame(0, 0, 0);
		check_all();
		frame(0, 0, 0);
		setc('h40);
		check_all();
		clr(6);
		clr(5);
		check_all();
		setc('h50);
		frame(1, 0, 0);
		frame(0, 1, 0);
		check_all();
		setc('h10);
		check_all();
		clr(4);
		clr(3);
		$display("test receive done");
		addr_frame_mode <= 1'b1;
		sync_mode <= 1'b1;
		setc('h58);
		frame(0, 0, 0);
		check_all();
		clr(6);
		sync_mode <= 1'b0;
		setc('h58);
		frame(0, 0, 0);
		check_all();
		frame(0, 0, 1);
		check_all();
		addr_frame_mode <= 1'b0;
		$display("test address wait done");
		for (i = 0; i < 6; i++) begin
			setc(i & 3);
			sync_mode <= (i > 3);
			repeat (2) @(posedge pclk);
			chk(32'({sck_oe_n, ext_clk_sel}), 32'({(i < 4) && (i != 1), i[1]}));
			for (j = 0; j < 8 && i == 1; j++) begin
				b = bit_clk;
				@(posedge pclk);
				chk(32'(sck_out), 32'(b));
			end
		end
		$display("test clock pin done");
		final_report();
	end
endmodule : tb
`default_nettype wire
